// >>> rtl/lpu_consts.svh
// Constants for the pixel unpack and palette stage.
// Assumes inclusion by the package and the design modules.
`ifndef LPU_CONSTS_SVH
`define LPU_CONSTS_SVH
`define LPU_WORD_W      32
`define LPU_VID_W       18
`define LPU_ENTRY_W     24
`define LPU_PAL_DEPTH   256
`define LPU_IDX_W       8
`define LPU_FIFO_DEPTH  8
`define LPU_FMT_666     2'h0
`define LPU_FMT_565     2'h1
`define LPU_FMT_5551    2'h3
`define LPU_BPP_8       2'h0
`define LPU_BPP_4       2'h1
`define LPU_BPP_2       2'h2
`endif

// >>> rtl/lpu_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-low reset.
module lpu_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  lpu_stream_if.src         out
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]   count, next_count;
  logic          push, pop;
  logic          next_in_ready;

  // ==========================================================================
  // Pointers and occupancy; empty comes straight from the count, full from next_count through a flop.
  always_comb begin
    push        = in_valid && in_ready;
    pop         = out.valid && out.ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW + 1)'(push) - (AW + 1)'(pop);
    // Ready is registered so the fetcher sees a clean flop output, not a decode.
    next_in_ready = (next_count != (AW + 1)'(D));
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // Storage carries no reset; only the pointers, count and in_ready need a defined value.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out.valid = (count != '0);
  assign out.data  = mem[rd_ptr];
endmodule

// >>> rtl/lpu_pkg.sv
// Types for the pixel unpack and palette stage.
// Assumes lpu_consts.svh is on the include path.
`include "lpu_consts.svh"
package lpu_pkg;
  typedef logic [`LPU_WORD_W-1:0]  lpu_word_t;
  typedef logic [`LPU_VID_W-1:0]   lpu_vid_t;
  typedef logic [`LPU_ENTRY_W-1:0] lpu_entry_t;
  typedef enum logic [1:0] {LPU_IDLE, LPU_BEAT1, LPU_BEAT2} lpu_beat_e;
endpackage

// >>> rtl/lpu_stream_if.sv
// Valid/ready word stream between the unpack stage and its input FIFO.
// Assumes one clock shared by both ends.
interface lpu_stream_if #(parameter int W = 32);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// >>> rtl/lpu_unpack.sv
// Pixel unpack, palette lookup and video pin formatting stage.
// Assumes words arrive from a frame fetcher; software obeys palette access timing.
// Summary of operation
// - Direct 8 bpp pixel is red 7:5, green 4:2, blue 1:0.
// - Direct 8 bpp parallel: red pins 17:15, green 11:9, blue 5:4.
// - Direct 8 bpp serial: three beats from pin 17, red, green, blue.
// - Palette is 256 entries of 24 bits, indexed by pixel value.
// - Palette entries read as 6:6:6, 5:6:5 or 5:5:5 plus intensity.
// - Intensity bit becomes the low bit of every colour channel.
// - 6:6:6 entry bits 17:0 go straight to pins 17:0 in parallel mode.
// - Intensity format: red 15:11, green 10:6, blue 5:1, intensity bit 0.
// - Intensity format in parallel mode drives pins 12, 6 and 0 with the intensity bit.
// - Palette write data bits 31:24 are discarded.
`include "lpu_consts.svh"
module lpu_unpack
  import lpu_pkg::*;
#(
  parameter int FIFO_DEPTH = `LPU_FIFO_DEPTH
) (
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic [`LPU_WORD_W-1:0]   word_data,
  input  wire logic                     word_valid,
  output logic                          word_ready,
  input  wire logic [1:0]               bpp_select,
  input  wire logic                     palette_enable,
  input  wire logic                     serial_mode,
  input  wire logic                     byte_swap_enable,
  input  wire logic                     halfword_swap_enable,
  input  wire logic [1:0]               palette_format_select,
  input  wire logic                     pal_write,
  input  wire logic [`LPU_IDX_W-1:0]    pal_addr,
  input  wire logic [`LPU_WORD_W-1:0]   pal_wdata,
  output logic [`LPU_ENTRY_W-1:0]       pal_rdata,
  input  wire logic                     pixel_ready,
  output logic [`LPU_VID_W-1:0]         video_data_out,
  output logic                          video_valid
);
  lpu_stream_if #(.W(`LPU_WORD_W)) fifo_out ();

  // Pipeline state: one word, one pixel and up to three pending serial beats.
  lpu_entry_t palette [`LPU_PAL_DEPTH];
  lpu_word_t  word, next_word;
  logic [4:0] slot, next_slot;
  logic       have_word, next_have_word;
  logic [7:0] pix, next_pix;
  logic       pix_pal, next_pix_pal;
  logic       pix_valid, next_pix_valid;
  lpu_vid_t   next_vid, beat2, next_beat2, beat3, next_beat3;
  logic       next_video_valid;
  lpu_beat_e  beat, next_beat;
  logic [`LPU_IDX_W-1:0] rd_idx;
  logic       adv, out_free;
  lpu_entry_t entry;

  // ==========================================================================
  // Input buffer; a stalled panel back-pressures the fetcher through word_ready.
  lpu_fifo #(.W(`LPU_WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .clock    (clock),
    .nrst     (nrst),
    .in_data  (word_data),
    .in_valid (word_valid),
    .in_ready (word_ready),
    .out      (fifo_out)
  );

  // Applies the byte and halfword swap options to a whole word.
  function automatic lpu_word_t swap_word(input lpu_word_t w, input logic bs, input logic hs);
    lpu_word_t r;
    r = w;
    if (bs) begin
      r = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
    if (hs) begin
      r = {r[15:0], r[31:16]};
    end
    return r;
  endfunction

  // Number of pixels per word less one, for the selected depth.
  function automatic logic [4:0] last_slot(input logic [1:0] b);
    unique case (b)
      `LPU_BPP_4: return 5'h07;
      `LPU_BPP_2: return 5'h0F;
      default:    return 5'h03;
    endcase
  endfunction

  // ==========================================================================
  // Palette store: a single port, shared by software and the pixel path.
  // Software access during active display stalls the lookup for that cycle.
  // A write wins the port for its cycle and the pixel path waits, so a late
  // write costs one pixel slot rather than showing a wrong colour.
  assign rd_idx = pal_write ? pal_addr : pix;
  // Only the 24 colour bits are kept; the top byte of the write word is dropped.
  always_ff @(posedge clock) begin
    if (pal_write) begin
      palette[pal_addr] <= pal_wdata[`LPU_ENTRY_W-1:0];
    end
  end
  // Combinational read; the registered copy on pal_rdata lets software read back.
  assign entry = palette[rd_idx];

  // ==========================================================================
  // Unpacker: pulls a word, then walks pixels from the top of the word down.
  // A word is released only when its last pixel moves on, so no pixel is lost.
  assign out_free     = (beat == LPU_IDLE) && (!video_valid || pixel_ready);
  assign adv          = out_free && !pal_write;
  assign fifo_out.ready = !have_word || (adv && (slot == last_slot(bpp_select)));

  always_comb begin
    next_word      = word;
    next_slot      = slot;
    next_have_word = have_word;
    next_pix       = pix;
    next_pix_pal   = pix_pal;
    next_pix_valid = pix_valid && !adv;
    if (have_word && adv) begin
      unique case (bpp_select)
        `LPU_BPP_4: next_pix = {4'h0, word[31 - 4*slot -: 4]};
        `LPU_BPP_2: next_pix = {6'h00, word[31 - 2*slot -: 2]};
        default:    next_pix = word[31 - 8*slot -: 8];
      endcase
      next_pix_pal   = palette_enable || (bpp_select != `LPU_BPP_8);
      next_pix_valid = 1'b1;
      next_slot      = slot + 5'h01;
      if (slot == last_slot(bpp_select)) begin
        next_have_word = 1'b0;
        next_slot      = '0;
      end
    end
    if (fifo_out.valid && fifo_out.ready) begin
      next_word      = swap_word(fifo_out.data, byte_swap_enable, halfword_swap_enable);
      next_have_word = 1'b1;
      next_slot      = '0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      word      <= '0;
      slot      <= '0;
      have_word <= 1'b0;
      pix       <= '0;
      pix_pal   <= 1'b0;
      pix_valid <= 1'b0;
    end else begin
      word      <= next_word;
      slot      <= next_slot;
      have_word <= next_have_word;
      pix       <= next_pix;
      pix_pal   <= next_pix_pal;
      pix_valid <= next_pix_valid;
    end
  end

  // ==========================================================================
  // Colour formatting and pin output, parallel or three serial beats.
  always_comb begin
    lpu_vid_t par;
    par = '0;
    if (!pix_pal) begin
      par[17:15] = pix[7:5];
      par[11:9]  = pix[4:2];
      par[5:4]   = pix[1:0];
    end else begin
      unique case (palette_format_select)
        `LPU_FMT_565: par = {entry[15:11], 1'b0, entry[10:5], entry[4:0], 1'b0};
        `LPU_FMT_5551: par = {entry[15:11], entry[0], entry[10:6], entry[0],
                              entry[5:1], entry[0]};
        default:       par = entry[17:0];
      endcase
    end
    next_beat        = beat;
    next_vid         = video_data_out;
    next_beat2       = beat2;
    next_beat3       = beat3;
    next_video_valid = video_valid && !pixel_ready;
    if (beat != LPU_IDLE) begin
      if (!video_valid || pixel_ready) begin
        next_vid         = beat2;
        next_beat2       = beat3;
        next_video_valid = 1'b1;
        next_beat        = (beat == LPU_BEAT1) ? LPU_BEAT2 : LPU_IDLE;
      end
    end else if (pix_valid && adv) begin
      next_video_valid = 1'b1;
      if (serial_mode) begin
        // Serial beats sit on the top six pins, red then green then blue.
        next_vid   = {par[17:12], 12'h000};
        next_beat2 = {par[11:6], 12'h000};
        next_beat3 = {par[5:0], 12'h000};
        next_beat  = LPU_BEAT1;
      end else begin
        next_vid = par;
      end
    end
  end

  // Output registers; every top-level output leaves from a flip-flop.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      beat           <= LPU_IDLE;
      video_data_out <= '0;
      beat2          <= '0;
      beat3          <= '0;
      video_valid    <= 1'b0;
      pal_rdata      <= '0;
    end else begin
      beat           <= next_beat;
      video_data_out <= next_vid;
      beat2          <= next_beat2;
      beat3          <= next_beat3;
      video_valid    <= next_video_valid;
      pal_rdata      <= entry;
    end
  end
endmodule

// >>> test/lpu_panel_model.sv
// Behavioural panel on the video pins: takes beats, can stall or pace them.
// Assumes one clock; the bench reads the captured queue directly.
module lpu_panel_model (
  input  wire logic        clock,
  input  wire logic [17:0] video_data_out,
  input  wire logic        video_valid,
  input  wire logic        hold,
  input  wire logic        slow,
  output logic             pixel_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Pacing and capture
  logic [17:0] got_q[$];
  logic        phase = 1'b0;
  // Ready moves only at the falling edge so the design samples it settled.
  always @(negedge clock) begin
    phase <= ~phase;
    pixel_ready <= !hold && (!slow || phase);
  end
  // A beat counts only on an edge showing both valid and ready.
  always @(posedge clock) begin
    if (video_valid && pixel_ready) got_q.push_back(video_data_out);
  end
endmodule

// >>> test/lpu_unpack_properties.sv
// Checker for the unpack stage, watching its top-level ports only.
// Assumes one clock domain and reset released on a clock edge.
`include "lpu_consts.svh"
module lpu_unpack_properties (
  input wire logic                   clock,
  input wire logic                   nrst,
  input wire logic                   word_valid,
  input wire logic                   word_ready,
  input wire logic [1:0]             bpp_select,
  input wire logic                   palette_enable,
  input wire logic                   serial_mode,
  input wire logic [1:0]             palette_format_select,
  input wire logic                   pixel_ready,
  input wire logic [`LPU_VID_W-1:0]  video_data_out,
  input wire logic                   video_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Beat tracking
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [1:0] beat;
  logic [1:0] next_beat;
  logic       dir;
  // Direct colour only in 8 bpp without palette; all else is a lookup.
  assign dir = (bpp_select == 2'h0) && !palette_enable;
  // Counts accepted serial beats so the third one can be picked out.
  always_comb begin
    next_beat = beat;
    if (!serial_mode) next_beat = 2'h0;
    else if (video_valid && pixel_ready) next_beat = (beat == 2'h2) ? 2'h0 : beat + 2'h1;
  end
  // Plain register for the beat count.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) beat <= 2'h0;
    else beat <= next_beat;
  end
  a_beat_hold: assert property (video_valid && !pixel_ready |=> video_valid && $stable(video_data_out))
    else $error("stalled beat changed");
  a_direct_par: assert property (video_valid && dir && !serial_mode |-> (video_data_out & 18'h071CF) == 18'h0)
    else $error("direct parallel colour on unused pins");
  a_direct_ser: assert property (video_valid && dir && serial_mode |-> video_data_out[11:0] == 12'h0)
    else $error("direct serial colour on low pins");
  a_blue_beat: assert property (video_valid && dir && serial_mode && beat == 2'h2 |-> video_data_out[15:0] == 16'h0)
    else $error("third beat wider than two bits");
  a_beat_next: assert property (video_valid && pixel_ready && dir && serial_mode && beat != 2'h2 |=> video_valid)
    else $error("serial beat missing");
  a_int_pins: assert property (video_valid && !dir && !serial_mode && palette_format_select == `LPU_FMT_5551
    |-> video_data_out[12] == video_data_out[6] && video_data_out[6] == video_data_out[0])
    else $error("intensity pins differ");
  a_mid_free: assert property (video_valid && !dir && !serial_mode && palette_format_select == `LPU_FMT_565
    |-> !video_data_out[12] && !video_data_out[0])
    else $error("unused pins driven in 5:6:5");
  a_ready_fall: assert property ($fell(word_ready) |-> $past(word_valid))
    else $error("word ready fell without a push");
endmodule

// >>> test/lpu_unpack_tb.sv
// Self-checking bench for the unpack stage with a pacing panel model.
// Assumes the design and package are compiled first.
bind lpu_unpack lpu_unpack_properties u_props (.*);
module lpu_unpack_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpu_pkg::*;
  // ==========================================================
  // Signals
  logic clock = 0, nrst = 0, word_valid, word_ready, palette_enable, serial_mode;
  logic byte_swap_enable, halfword_swap_enable, pal_write, pixel_ready, video_valid, hold, slow;
  logic [1:0] bpp_select, palette_format_select;
  logic [7:0] pal_addr, cfg [8] = '{8'h10, 8'h20, 8'h29, 8'h27, 8'h4A, 8'h47, 8'h8D, 8'h90};
  lpu_word_t word_data, pal_wdata;
  lpu_entry_t pal_rdata, pal [256];
  lpu_vid_t video_data_out, exp_q[$], msk_q[$];
  int err_total, total_checks, cyc, n;
  lpu_unpack DUT (.*);
  lpu_panel_model u_panel (.*);
  initial forever #10 clock = ~clock;
  // A run far past the expected thousand or so cycles counts as a hang.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(lpu_vid_t g, lpu_vid_t e, lpu_vid_t m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, g & m, e & m);
    end
  endtask
  // Palette read-back compare, full 24-bit entry.
  task automatic chk_pal(lpu_entry_t g, lpu_entry_t e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Queues the beats a word must produce; all 18 pins are compared, unused pins as zero.
  task automatic put(lpu_word_t w);
    lpu_word_t v;
    int b;
    logic [7:0] p;
    lpu_entry_t e;
    lpu_vid_t x;
    v = byte_swap_enable ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    if (halfword_swap_enable) v = {v[15:0], v[31:16]};
    b = 8 >> bpp_select;
    for (int i = 0; i < 32 / b; i++) begin
      p = 8'((v >> (32 - b * (i + 1))) & ((32'h1 << b) - 1));
      e = pal[p];
      if (!palette_enable && bpp_select == 2'h0) x = {p[7:5], 3'h0, p[4:2], 3'h0, p[1:0], 4'h0};
      else if (palette_format_select == 2'h1) x = {e[15:11], 1'b0, e[10:5], e[4:0], 1'b0};
      else if (palette_format_select == 2'h3) x = {e[15:11], e[0], e[10:6], e[0], e[5:1], e[0]};
      else x = e[17:0];
      repeat (serial_mode ? 3 : 1) msk_q.push_back(18'h3FFFF);
      // Serial mode sends the parallel word as three six-pin slices on the top pins.
      if (serial_mode) begin
        exp_q.push_back({x[17:12], 12'h0});
        exp_q.push_back({x[11:6], 12'h0});
        exp_q.push_back({x[5:0], 12'h0});
      end else exp_q.push_back(x);
    end
  endtask
  // Offers a word from a falling edge and returns at the falling edge after it is taken.
  task automatic send(lpu_word_t w);
    put(w);
    word_data = w;
    word_valid = 1;
    while (!word_ready) @(negedge clock);
    @(negedge clock);
  endtask
  task automatic drain();
    for (int t = 0; t < 2000 && u_panel.got_q.size() < exp_q.size(); t++) @(negedge clock);
    chk(18'(u_panel.got_q.size()), 18'(exp_q.size()), 18'h3FFFF);
    while (exp_q.size() > 0 && u_panel.got_q.size() > 0) chk(u_panel.got_q.pop_front(), exp_q.pop_front(), msk_q.pop_front());
    exp_q.delete();
    msk_q.delete();
    u_panel.got_q.delete();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {word_valid, pal_write, palette_enable, serial_mode, halfword_swap_enable, hold, slow} = '0;
    {bpp_select, palette_format_select, pal_addr, word_data, pal_wdata} = '0;
    byte_swap_enable = 1;
    repeat (16) @(negedge clock);
    nrst = 1;
    // Palette is loaded while nothing is displayed, before any format is used.
    @(negedge clock);
    pal_write = 1;
    for (int i = 0; i < 256; i++) begin
      pal[i] = 24'(i * 32'h9E3779);
      pal_addr = 8'(i);
      pal_wdata = {8'hA5, pal[i]};
      @(negedge clock);
    end
    // Rewriting an entry with its own colour reads the stored entry back a cycle later.
    for (int k = 0; k < 4; k++) begin
      pal_addr = 8'(k * 85);
      pal_wdata = {8'h5A, pal[k * 85]};
      @(negedge clock);
      chk_pal(pal_rdata, pal[k * 85]);
    end
    pal_write = 0;
    // Stalled panel: words pile up until the buffer refuses.
    hold = 1;
    do begin
      send(32'h9C2E71B5 ^ (n * 32'h0F1E2D3C));
      n++;
    end while (word_ready && n < 16);
    word_valid = 0;
    chk({17'h0, word_ready}, 18'h0, 18'h1);
    chk({17'h0, n >= 8}, 18'h1, 18'h1);
    hold = 0;
    slow = 1;
    drain();
    for (int i = 0; i < 8; i++) begin
      {bpp_select, palette_enable, serial_mode, byte_swap_enable, halfword_swap_enable, palette_format_select} = cfg[i];
      slow = i[0];
      for (int k = 0; k < 3; k++) send(32'h9C2E71B5 ^ (k * 32'h0F1E2D3C) ^ (i << 4));
      word_valid = 0;
      drain();
    end
    summarize();
  end
endmodule
